// ==== verilog/burst_restart_pkg.sv ====
// constants for the burst and restart control block
// assumes a 125 MHz core clock; comparator flags are synchronised inside the control block
package burst_restart_pkg;
    localparam int CLK_HZ             = 125_000_000;
    localparam int BLANK_MS           = 20;
    localparam int BLANK_CYCLES       = CLK_HZ / 1000 * BLANK_MS;
    localparam int SPIKE_US           = 30;
    localparam int SPIKE_CYCLES       = CLK_HZ / 1_000_000 * SPIKE_US;
    localparam int DETECT_MS          = 1;
    localparam int DETECT_CYCLES      = CLK_HZ / 1000 * DETECT_MS;
    localparam int EXT_COUNT_TOTAL    = 256;
    localparam int CNT_W              = 24;
    localparam logic [15:0] LVL1_MIN  = 16'h0000;
    localparam logic [15:0] LVL2_MIN  = 16'h0004;
    localparam logic [15:0] LVL3_MIN  = 16'h0010;
    localparam logic [15:0] LVL4_MIN  = 16'h0040;
    localparam logic [1:0]  LVL_NEVER = 2'h3;

    typedef enum logic [1:0] {
        RESTART_NONE,
        RESTART_NORMAL,
        RESTART_ODD_SKIP,
        RESTART_NON_SWITCH
    } restart_mode_e;
endpackage : burst_restart_pkg

// ==== verilog/burst_and_restart_control.sv ====
// burst mode and auto-restart sequencing for an off-line switching controller
// assumes comparator and thermal inputs are asynchronous to clk_in
// What this block does
// - blanking counter held at zero normally, counts once feedback below entry level.
// - burst entered only if counter hits 20 ms with feedback still low.
// - on burst entry set burst flag and switch internal bias off.
// - in burst, feedback above 3.5V turns bias on and resumes switching.
// - burst mode selects the reduced burst current limit.
// - in burst, feedback down to 3.2V switches bias off again.
// - feedback above 4.0V in burst clears burst, restores full current limit.
// - odd-skip mode: odd cycles no detection nor switching, even cycles both.
// - odd-skip releases only in even cycle with fault gone.
// - non-switch mode: no switching even cycles, detect there, release when clear.
// - both over-voltages, over-load and open loop map to odd-skip restart.
// - under-voltage and shorted opto lead to normal restart via lockout.
// - first over-voltage acts only in soft start with high supply and feedback.
// - second over-voltage acts in normal and burst states, without the soft-start condition, and forces odd-skip restart.
// - over-temperature forces non-switch restart, recovery after hysteresis drop.
// - multi-function pin pulled low stops gate drive, non-switch restart.
// - below lockout shut down, enable start-up cell; restart at turn-on level.
// - feedback above 4.5V starts blanking; at 20 ms extended counter starts.
// - extended counter discharges to 0.9V, charges to 4.5V, counts each 4.5V crossing.
// - at 256 counts counter stops; restart follows after 30 us spike blanking.
// - burst thresholds chosen once from oscillation count in first 1 ms.
`timescale 1ns/1ps
`default_nettype none
module burst_and_restart_control #(
    parameter int BLANK_CYC = burst_restart_pkg::BLANK_CYCLES,
    parameter int SPIKE_CYC = burst_restart_pkg::SPIKE_CYCLES,
    parameter int DETECT_CYC = burst_restart_pkg::DETECT_CYCLES,
    parameter int EXT_TOTAL = burst_restart_pkg::EXT_COUNT_TOTAL
) (
    input  wire logic       clk_in,
    input  wire logic       resetn_in,
    input  wire logic       burst_entry_comparator_in,
    input  wire logic       burst_wake_comparator_in,
    input  wire logic       burst_sleep_comparator_in,
    input  wire logic       burst_exit_comparator_in,
    input  wire logic       overload_comparator_in,
    input  wire logic       upper_charge_comparator_in,
    input  wire logic       lower_discharge_comparator_in,
    input  wire logic       ext_protect_in,
    input  wire logic       ovp1_supply_in,
    input  wire logic       supply_overvoltage_trip_in,
    input  wire logic       thermal_trip_in,
    input  wire logic       thermal_clear_in,
    input  wire logic       supply_lockout_off_in,
    input  wire logic       supply_lockout_on_in,
    input  wire logic       soft_start_in,
    input  wire logic       fbb_osc_pulse_in,
    output logic            bias_enable_out,
    output logic            switch_enable_out,
    output logic            burst_current_limit_out,
    output logic            burst_flag_out,
    output logic            startup_cell_enable_out,
    output logic            charge_switch_out,
    output logic            discharge_switch_out,
    output logic [1:0]      restart_mode_out,
    output logic [1:0]      burst_level_out
);
    localparam int NS = 15;
    localparam int CW = burst_restart_pkg::CNT_W;

    // two-flop synchronisers for all analog flags
    logic [NS-1:0] raw;
    logic [NS-1:0] s1_r;
    logic [NS-1:0] s2_r;
    assign raw = {burst_entry_comparator_in, burst_wake_comparator_in,
                  burst_sleep_comparator_in, burst_exit_comparator_in,
                  overload_comparator_in, upper_charge_comparator_in,
                  lower_discharge_comparator_in, ext_protect_in,
                  ovp1_supply_in, supply_overvoltage_trip_in,
                  thermal_trip_in, thermal_clear_in, supply_lockout_off_in,
                  supply_lockout_on_in, fbb_osc_pulse_in};
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            s1_r <= '0;
            s2_r <= '0;
        end else begin
            s1_r <= raw;
            s2_r <= s1_r;
        end
    end
    logic fb_low, wake, sleep, bexit, ovl, up_hit, lo_hit, ext_pr;
    logic ovp1, ovp2, ot_trip, ot_clr, uv_off, uv_on, osc;
    assign {fb_low, wake, sleep, bexit, ovl, up_hit, lo_hit, ext_pr,
            ovp1, ovp2, ot_trip, ot_clr, uv_off, uv_on, osc} = s2_r;

    typedef enum logic [2:0] {
        ST_OFF, ST_DETECT, ST_NORMAL, ST_BURST, ST_RESTART
    } state_e;
    typedef enum logic [1:0] { EB_IDLE, EB_DISCH, EB_CHG, EB_DONE } ext_e;

    state_e                            st_r, st_nxt;
    ext_e                              eb_r, eb_nxt;
    burst_restart_pkg::restart_mode_e  mode_r, mode_nxt;
    logic [CW-1:0] bcnt_r, bcnt_nxt;
    logic [CW-1:0] ocnt_r, ocnt_nxt;
    logic [CW-1:0] spk_r, spk_nxt;
    logic [CW-1:0] det_r, det_nxt;
    logic [15:0]   osc_r, osc_nxt;
    logic [8:0]    ecnt_r, ecnt_nxt;
    logic [1:0]    lvl_r, lvl_nxt;
    logic          lvl_done_r, lvl_done_nxt;
    logic          odd_r, odd_nxt;
    logic          bias_r, bias_nxt;
    logic          sw_r, sw_nxt;
    logic          cl_r, cl_nxt;
    logic          flag_r, flag_nxt;
    logic          cell_r, cell_nxt;
    logic          cycled_r, cycled_nxt;
    logic          ot_hold_r, ot_hold_nxt;
    logic          osc_d_r;

    // burst level from detect-window oscillation count; under 4 pulses means never
    function automatic logic [1:0] level_of(input logic [15:0] n);
        if (n >= burst_restart_pkg::LVL4_MIN) level_of = 2'h0;
        else if (n >= burst_restart_pkg::LVL3_MIN) level_of = 2'h1;
        else if (n >= burst_restart_pkg::LVL2_MIN) level_of = 2'h2;
        else level_of = burst_restart_pkg::LVL_NEVER;
    endfunction : level_of

    logic odd_fault, ns_fault, burst_allowed;
    always_comb begin
        odd_fault = ovp2 || (ovp1 && ovl && soft_start_in)
                    || (eb_r == EB_DONE && spk_r >= CW'(SPIKE_CYC));
        ns_fault = ot_hold_r || ext_pr;
        burst_allowed = (lvl_r != burst_restart_pkg::LVL_NEVER);
    end

    always_comb begin
        st_nxt = st_r;
        eb_nxt = eb_r;
        mode_nxt = mode_r;
        bcnt_nxt = bcnt_r;
        ocnt_nxt = ocnt_r;
        spk_nxt = spk_r;
        det_nxt = det_r;
        osc_nxt = osc_r;
        ecnt_nxt = ecnt_r;
        lvl_nxt = lvl_r;
        lvl_done_nxt = lvl_done_r;
        odd_nxt = odd_r;
        bias_nxt = bias_r;
        sw_nxt = sw_r;
        cl_nxt = cl_r;
        flag_nxt = flag_r;
        cell_nxt = cell_r;
        cycled_nxt = cycled_r;
        ot_hold_nxt = ot_hold_r;
        if (ot_trip) ot_hold_nxt = 1'b1;
        else if (ot_clr) ot_hold_nxt = 1'b0;
        case (st_r)
            ST_OFF: begin
                bias_nxt = 1'b0;
                sw_nxt = 1'b0;
                cell_nxt = 1'b1;
                if (uv_on) begin
                    cell_nxt = 1'b0;
                    bias_nxt = 1'b1;
                    if (mode_r == burst_restart_pkg::RESTART_NONE ||
                        mode_r == burst_restart_pkg::RESTART_NORMAL) begin
                        mode_nxt = burst_restart_pkg::RESTART_NONE;
                        st_nxt = lvl_done_r ? ST_NORMAL : ST_DETECT;
                        sw_nxt = lvl_done_r;
                        det_nxt = '0;
                        osc_nxt = '0;
                    end else begin
                        st_nxt = ST_RESTART;
                        odd_nxt = ~odd_r;
                        cycled_nxt = 1'b1;
                    end
                end
            end
            ST_DETECT: begin
                det_nxt = det_r + CW'(1);
                if (osc && !osc_d_r) osc_nxt = osc_r + 16'h0001;
                if (det_r >= CW'(DETECT_CYC)) begin
                    lvl_nxt = level_of(osc_r);
                    lvl_done_nxt = 1'b1;
                    st_nxt = ST_NORMAL;
                    sw_nxt = 1'b1;
                end
            end
            ST_NORMAL: begin
                cl_nxt = 1'b0;
                if (fb_low && burst_allowed) begin
                    bcnt_nxt = bcnt_r + CW'(1);
                    if (bcnt_r >= CW'(BLANK_CYC)) begin
                        st_nxt = ST_BURST;
                        flag_nxt = 1'b1;
                        bias_nxt = 1'b0;
                        sw_nxt = 1'b0;
                        cl_nxt = 1'b1;
                        bcnt_nxt = '0;
                    end
                end else begin
                    bcnt_nxt = '0;
                end
            end
            ST_BURST: begin
                cl_nxt = 1'b1;
                if (bexit) begin
                    st_nxt = ST_NORMAL;
                    flag_nxt = 1'b0;
                    cl_nxt = 1'b0;
                    bias_nxt = 1'b1;
                    sw_nxt = 1'b1;
                end else if (wake) begin
                    bias_nxt = 1'b1;
                    sw_nxt = 1'b1;
                end else if (sleep) begin
                    bias_nxt = 1'b0;
                    sw_nxt = 1'b0;
                end
            end
            ST_RESTART: begin
                // odd cycles of odd-skip: no detect, no switching
                sw_nxt = !odd_r &&
                         (mode_r == burst_restart_pkg::RESTART_ODD_SKIP);
                // no release before the first lockout cycle has run
                if (cycled_r && !odd_r && !odd_fault && !ns_fault) begin
                    st_nxt = ST_NORMAL;
                    mode_nxt = burst_restart_pkg::RESTART_NONE;
                    sw_nxt = 1'b1;
                end
            end
            default: st_nxt = ST_OFF;
        endcase
        // overload blanking and extended counter
        if (st_r == ST_NORMAL || st_r == ST_BURST) begin
            if (ovl) begin
                if (ocnt_r < CW'(BLANK_CYC)) ocnt_nxt = ocnt_r + CW'(1);
            end else begin
                ocnt_nxt = '0;
            end
        end else begin
            ocnt_nxt = '0;
        end
        case (eb_r)
            EB_IDLE: if (ovl && ocnt_r >= CW'(BLANK_CYC)) begin
                eb_nxt = EB_DISCH;
                ecnt_nxt = '0;
            end
            EB_DISCH: if (lo_hit) eb_nxt = EB_CHG;
            EB_CHG: if (up_hit) begin
                ecnt_nxt = ecnt_r + 9'h001;
                eb_nxt = (ecnt_r + 9'h001 >= 9'(EXT_TOTAL)) ?
                         EB_DONE : EB_DISCH;
            end
            EB_DONE: spk_nxt = spk_r + CW'(1);
            default: eb_nxt = EB_IDLE;
        endcase
        if (!ovl || ext_pr || st_r == ST_RESTART || st_r == ST_OFF) begin
            eb_nxt = EB_IDLE; // external request overrides blanking
            spk_nxt = '0;
        end
        // protection entry from running states
        if (st_r == ST_NORMAL || st_r == ST_BURST) begin
            if (ns_fault || odd_fault) begin
                mode_nxt = ns_fault ? burst_restart_pkg::RESTART_NON_SWITCH
                                    : burst_restart_pkg::RESTART_ODD_SKIP;
                st_nxt = ST_RESTART;
                odd_nxt = 1'b0;
                cycled_nxt = 1'b0;
                sw_nxt = 1'b0;
                flag_nxt = 1'b0;
                cl_nxt = 1'b0;
            end
        end
        if (uv_off && st_r != ST_OFF) begin
            if (st_r != ST_RESTART)
                mode_nxt = burst_restart_pkg::RESTART_NORMAL;
            st_nxt = ST_OFF;
            sw_nxt = 1'b0;
            bias_nxt = 1'b0;
            cell_nxt = 1'b1;
            flag_nxt = 1'b0;
            cl_nxt = 1'b0;
        end
    end

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            st_r <= ST_OFF;
            eb_r <= EB_IDLE;
            mode_r <= burst_restart_pkg::RESTART_NONE;
            bcnt_r <= '0;
            ocnt_r <= '0;
            spk_r <= '0;
            det_r <= '0;
            osc_r <= '0;
            ecnt_r <= '0;
            lvl_r <= burst_restart_pkg::LVL_NEVER;
            lvl_done_r <= 1'b0;
            odd_r <= 1'b0;
            bias_r <= 1'b0;
            sw_r <= 1'b0;
            cl_r <= 1'b0;
            flag_r <= 1'b0;
            cell_r <= 1'b1;
            cycled_r <= 1'b0;
            ot_hold_r <= 1'b0;
            osc_d_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            eb_r <= eb_nxt;
            mode_r <= mode_nxt;
            bcnt_r <= bcnt_nxt;
            ocnt_r <= ocnt_nxt;
            spk_r <= spk_nxt;
            det_r <= det_nxt;
            osc_r <= osc_nxt;
            ecnt_r <= ecnt_nxt;
            lvl_r <= lvl_nxt;
            lvl_done_r <= lvl_done_nxt;
            odd_r <= odd_nxt;
            bias_r <= bias_nxt;
            sw_r <= sw_nxt;
            cl_r <= cl_nxt;
            flag_r <= flag_nxt;
            cell_r <= cell_nxt;
            cycled_r <= cycled_nxt;
            ot_hold_r <= ot_hold_nxt;
            osc_d_r <= osc;
        end
    end

    // outputs straight from registers
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            charge_switch_out <= 1'b0;
            discharge_switch_out <= 1'b0;
        end else begin
            charge_switch_out <= (eb_nxt == EB_CHG);
            discharge_switch_out <= (eb_nxt == EB_DISCH);
        end
    end
    assign bias_enable_out = bias_r;
    assign switch_enable_out = sw_r;
    assign burst_current_limit_out = cl_r;
    assign burst_flag_out = flag_r;
    assign startup_cell_enable_out = cell_r;
    assign restart_mode_out = mode_r;
    assign burst_level_out = lvl_r;
endmodule : burst_and_restart_control
`default_nettype wire

// ==== tb/brc_partner.sv ====
// analog side model: comparators, supply monitor, multi-function pin
// assumes levels in mV and deg C are driven by the bench
`timescale 1ns/1ps
`default_nettype none
module brc_partner (
    input  wire logic        clk_in,
    input  wire logic        charge_switch_out,
    input  wire logic        discharge_switch_out,
    input  wire logic        pull_low,
    input  wire logic [1:0]  burst_level_out,
    input  wire logic [15:0] fb_mv,
    input  wire logic [15:0] vcc_mv,
    input  wire logic [7:0]  temp_c,
    output logic burst_entry_comparator_in, burst_wake_comparator_in,
    output logic burst_sleep_comparator_in, burst_exit_comparator_in,
    output logic overload_comparator_in, upper_charge_comparator_in,
    output logic lower_discharge_comparator_in, ext_protect_in,
    output logic ovp1_supply_in, supply_overvoltage_trip_in,
    output logic thermal_trip_in, thermal_clear_in,
    output logic supply_lockout_off_in, supply_lockout_on_in
);
    logic [15:0] thr;
    logic [15:0] mf_mv = 16'h07d0;
    always_comb begin
        case (burst_level_out)
            2'h0: thr = 16'h0640;
            2'h1: thr = 16'h058c;
            2'h2: thr = 16'h04f6;
            default: thr = 16'h0000;
        endcase
    end
    // pin rests at the tie-up level when no switch acts
    always @(posedge clk_in) begin
        if (pull_low)
            mf_mv <= 16'h0000;
        else if (discharge_switch_out)
            mf_mv <= (mf_mv > 16'h05dc) ? mf_mv - 16'h0258 : 16'h0384;
        else if (charge_switch_out)
            mf_mv <= (mf_mv < 16'h1004) ? mf_mv + 16'h0190 : 16'h1194;
        else
            mf_mv <= 16'h07d0;
    end
    assign burst_entry_comparator_in = fb_mv < thr;
    assign burst_wake_comparator_in = fb_mv > 16'h0dac;
    assign burst_sleep_comparator_in = fb_mv <= 16'h0c80;
    assign burst_exit_comparator_in = fb_mv > 16'h0fa0;
    assign overload_comparator_in = fb_mv > 16'h1194;
    assign upper_charge_comparator_in = mf_mv >= 16'h1194;
    assign lower_discharge_comparator_in = mf_mv <= 16'h0384;
    assign ext_protect_in = mf_mv < 16'h0190;
    assign ovp1_supply_in = vcc_mv > 16'h5014;
    assign supply_overvoltage_trip_in = vcc_mv > 16'h639c;
    assign thermal_trip_in = temp_c > 8'h82;
    assign thermal_clear_in = temp_c <= 8'h50;
    assign supply_lockout_off_in = vcc_mv < 16'h2904;
    assign supply_lockout_on_in = vcc_mv >= 16'h4268;
endmodule : brc_partner
`default_nettype wire

// ==== tb/brc_assertions.sv ====
// port-level checks of burst and restart control
// assumes it is bound to the design top, comparator flags are levels
`timescale 1ns/1ps
`default_nettype none
module brc_assertions (
    input wire logic clk_in, resetn_in, burst_entry_comparator_in,
    input wire logic burst_wake_comparator_in, burst_sleep_comparator_in,
    input wire logic burst_exit_comparator_in, ext_protect_in,
    input wire logic supply_overvoltage_trip_in, thermal_trip_in,
    input wire logic supply_lockout_off_in, bias_enable_out,
    input wire logic switch_enable_out, burst_current_limit_out,
    input wire logic burst_flag_out, startup_cell_enable_out,
    input wire logic charge_switch_out, discharge_switch_out,
    input wire logic [1:0] restart_mode_out,
    input wire logic [1:0] burst_level_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!resetn_in);
    // condition seen with a guard, then held for three more samples
    sequence held_s(c, g);
        (g && c) ##1 c [*3];
    endsequence
    burst_entry_a: assert property (
        $rose(burst_flag_out) |-> $past(burst_entry_comparator_in, 3)
        && !bias_enable_out && burst_current_limit_out)
        else $error("burst entry without cause");
    burst_limit_a: assert property (
        burst_flag_out |-> burst_current_limit_out)
        else $error("burst without reduced limit");
    never_burst_a: assert property (
        burst_level_out == burst_restart_pkg::LVL_NEVER |-> !burst_flag_out)
        else $error("burst entered at never level");
    bias_wake_a: assert property (
        held_s(burst_wake_comparator_in, burst_flag_out && !bias_enable_out)
        |-> ##[0:2] bias_enable_out)
        else $error("bias not resumed");
    bias_sleep_a: assert property (
        held_s(burst_sleep_comparator_in, burst_flag_out && bias_enable_out)
        |-> ##[0:2] !bias_enable_out)
        else $error("bias not switched off");
    burst_exit_a: assert property (
        held_s(burst_exit_comparator_in, burst_flag_out)
        |-> ##[0:2] (!burst_flag_out && !burst_current_limit_out))
        else $error("burst not left");
    ext_stop_a: assert property (
        held_s(ext_protect_in, switch_enable_out) |-> ##[0:2]
        (restart_mode_out == burst_restart_pkg::RESTART_NON_SWITCH
        && !switch_enable_out))
        else $error("external protection ignored");
    ovp_trip_a: assert property (
        held_s(supply_overvoltage_trip_in, switch_enable_out) |-> ##[0:2]
        restart_mode_out == burst_restart_pkg::RESTART_ODD_SKIP)
        else $error("overvoltage ignored");
    thermal_trip_a: assert property (
        held_s(thermal_trip_in, switch_enable_out) |-> ##[0:2]
        restart_mode_out == burst_restart_pkg::RESTART_NON_SWITCH)
        else $error("overtemperature ignored");
    lockout_cell_a: assert property (
        supply_lockout_off_in [*4] |-> ##[0:2] startup_cell_enable_out)
        else $error("start-up cell not enabled");
    nonswitch_off_a: assert property (
        restart_mode_out == burst_restart_pkg::RESTART_NON_SWITCH [*2]
        |-> !switch_enable_out)
        else $error("switching in non-switch restart");
    pin_switch_a: assert property (
        !(charge_switch_out && discharge_switch_out))
        else $error("charge and discharge together");
endmodule : brc_assertions
bind burst_and_restart_control brc_assertions chk (.*);
`default_nettype wire

// ==== tb/tb.sv ====
// self-checking bench for burst and restart control
// assumes shortened counts and the analog model in brc_partner
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic clk_in, resetn_in, soft_start_in, fbb_osc_pulse_in, pull_low;
    logic [15:0] fb_mv, vcc_mv;
    logic [7:0]  temp_c;
    logic burst_entry_comparator_in, burst_wake_comparator_in;
    logic burst_sleep_comparator_in, burst_exit_comparator_in;
    logic overload_comparator_in, upper_charge_comparator_in;
    logic lower_discharge_comparator_in, ext_protect_in, ovp1_supply_in;
    logic supply_overvoltage_trip_in, thermal_trip_in, thermal_clear_in;
    logic supply_lockout_off_in, supply_lockout_on_in;
    logic bias_enable_out, switch_enable_out, burst_current_limit_out;
    logic burst_flag_out, startup_cell_enable_out;
    logic charge_switch_out, discharge_switch_out;
    logic [1:0] restart_mode_out, burst_level_out;
    int failures = 0;
    int compares = 0;
    burst_and_restart_control #(.BLANK_CYC(20), .SPIKE_CYC(5),
        .DETECT_CYC(200), .EXT_TOTAL(4)) dut (.*);
    brc_partner partner (.*);
    initial begin
        clk_in = 1'b0;
        forever #4 clk_in = ~clk_in;
    end
    task automatic stop_test;
        if (failures == 0 && compares > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : stop_test
    task automatic chk(input logic [1:0] got, input logic [1:0] exp);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_in);
    endtask : cyc
    task automatic wait_mode(input logic [1:0] m, input int lim);
        for (int i = 0; i < lim && restart_mode_out !== m; i++) cyc(1);
        chk(restart_mode_out, m);
        if (restart_mode_out !== m) stop_test();
    endtask : wait_mode
    task automatic wait_sw;
        for (int i = 0; i < 300 && switch_enable_out !== 1'b1; i++) cyc(1);
        chk({1'b0, switch_enable_out}, 2'h1);
        if (switch_enable_out !== 1'b1) stop_test();
    endtask : wait_sw
    task automatic restart(input int n);
        repeat (n) begin
            vcc_mv <= 16'h2710;
            cyc(8);
            chk({1'b0, startup_cell_enable_out}, 2'h1);
            vcc_mv <= 16'h4650;
            cyc(8);
        end
    endtask : restart
    // odd cycle keeps the mode, even cycle with no fault releases
    task automatic recover(input logic [1:0] m);
        restart(1);
        chk(restart_mode_out, m);
        restart(1);
        wait_mode(2'h0, 100);
        wait_sw();
    endtask : recover
    task automatic t_start;
        vcc_mv <= 16'h4650;
        repeat (20) begin
            fbb_osc_pulse_in <= 1'b1;
            cyc(2);
            fbb_osc_pulse_in <= 1'b0;
            cyc(2);
        end
        wait_sw();
        chk(burst_level_out, 2'h1);
        chk({1'b0, startup_cell_enable_out}, 2'h0);
    endtask : t_start
    task automatic t_burst;
        fb_mv <= 16'h03e8;
        cyc(12);
        fb_mv <= 16'h09c4;
        cyc(30);
        chk({1'b0, burst_flag_out}, 2'h0);
        fb_mv <= 16'h03e8;
        cyc(15);
        chk({1'b0, burst_flag_out}, 2'h0);
        cyc(12);
        chk({burst_flag_out, bias_enable_out}, 2'h2);
        fb_mv <= 16'h0e10;
        cyc(6);
        chk({burst_current_limit_out, bias_enable_out}, 2'h3);
        fb_mv <= 16'h0c1c;
        cyc(6);
        chk({1'b0, bias_enable_out}, 2'h0);
        fb_mv <= 16'h1068;
        cyc(6);
        chk({burst_flag_out, burst_current_limit_out}, 2'h0);
        fb_mv <= 16'h09c4;
        cyc(6);
    endtask : t_burst
    task automatic t_ovp1;
        fb_mv <= 16'h12c0;
        vcc_mv <= 16'h5208;
        cyc(10);
        chk(restart_mode_out, 2'h0);
        soft_start_in <= 1'b1;
        cyc(6);
        chk(restart_mode_out, 2'h2);
        soft_start_in <= 1'b0;
        fb_mv <= 16'h09c4;
        recover(2'h2);
    endtask : t_ovp1
    task automatic t_overload;
        fb_mv <= 16'h12c0;
        cyc(15);
        chk(restart_mode_out, 2'h0);
        wait_mode(2'h2, 400);
        fb_mv <= 16'h09c4;
        recover(2'h2);
    endtask : t_overload
    task automatic t_faults;
        pull_low <= 1'b1;
        cyc(6);
        chk({restart_mode_out == 2'h3, switch_enable_out}, 2'h2);
        pull_low <= 1'b0;
        recover(2'h3);
        vcc_mv <= 16'h6590;
        cyc(6);
        chk(restart_mode_out, 2'h2);
        recover(2'h2);
        temp_c <= 8'h8c;
        cyc(6);
        chk(restart_mode_out, 2'h3);
        temp_c <= 8'h64;
        restart(2);
        chk(restart_mode_out, 2'h3);
        temp_c <= 8'h46;
        recover(2'h3);
        vcc_mv <= 16'h2710;
        cyc(6);
        chk(restart_mode_out, 2'h1);
        vcc_mv <= 16'h4650;
        wait_mode(2'h0, 300);
    endtask : t_faults
    initial begin
        resetn_in = 1'b0;
        soft_start_in = 1'b0;
        fbb_osc_pulse_in = 1'b0;
        pull_low = 1'b0;
        fb_mv = 16'h09c4;
        vcc_mv = 16'h1f40;
        temp_c = 8'h28;
        cyc(12);
        resetn_in <= 1'b1;
        cyc(2);
        t_start();
        t_burst();
        t_ovp1();
        t_overload();
        t_faults();
        stop_test();
    end
endmodule : tb
`default_nettype wire
